// ==== logic/dpd_consts.svh ====
// Widths and encodings for the differential demodulator and discriminator
`ifndef DPD_CONSTS_SVH
`define DPD_CONSTS_SVH
`define DPD_SAMPLE_W   8
`define DPD_PROD_W     17
`define DPD_FERR_W     18
`define DPD_SYM_W      2
`define DPD_MODE_BPSK  1'h0
`define DPD_MODE_QPSK  1'h1
`define DPD_ROT_NONE   2'h0
`define DPD_ROT_P45    2'h1
`define DPD_ROT_M45    2'h2
`endif

// ==== logic/dpd_pkg.sv ====
// Types shared by the differential demodulator files
package dpd_pkg;
`include "dpd_consts.svh"

    typedef enum logic {
        DPD_BPSK = `DPD_MODE_BPSK,
        DPD_QPSK = `DPD_MODE_QPSK
    } dpd_mode_t;

    typedef enum logic [1:0] {
        DPD_ROT_NONE = `DPD_ROT_NONE,
        DPD_ROT_P45  = `DPD_ROT_P45,
        DPD_ROT_M45  = `DPD_ROT_M45
    } dpd_rot_t;

    typedef struct packed {
        logic signed [`DPD_SAMPLE_W-1:0] i;
        logic signed [`DPD_SAMPLE_W-1:0] q;
    } dpd_sym_t;

    typedef struct packed {
        logic        [`DPD_SYM_W-1:0]  sym;
        logic signed [`DPD_FERR_W-1:0] ferr;
    } dpd_result_t;
endpackage

// ==== logic/dpd_skid.sv ====
// Two-entry skid buffer with registered ready and registered output
`timescale 1ns/1ps
module dpd_skid #(
    parameter int W = 20
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst_b,
    // Filling side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    logic         main_v_r;
    logic         main_v_nxt;
    logic         skid_v_r;
    logic         skid_v_nxt;
    logic [W-1:0] main_r;
    logic [W-1:0] main_nxt;
    logic [W-1:0] skid_r;
    logic [W-1:0] skid_nxt;
    logic         rdy_r;
    logic         rdy_nxt;
    logic         take;

    assign take      = in_valid && rdy_r;
    assign in_ready  = rdy_r;
    assign out_valid = main_v_r;
    assign out_data  = main_r;

    always_comb begin
        main_v_nxt = main_v_r;
        main_nxt   = main_r;
        skid_v_nxt = skid_v_r;
        skid_nxt   = skid_r;
        if (!main_v_r || out_ready) begin
            if (skid_v_r) begin
                main_v_nxt = 1'b1;
                main_nxt   = skid_r;
                skid_v_nxt = take;
                if (take) begin
                    skid_nxt = in_data;
                end
            end else begin
                main_v_nxt = take;
                if (take) begin
                    main_nxt = in_data;
                end
            end
        end else if (take) begin
            skid_v_nxt = 1'b1;
            skid_nxt   = in_data;
        end
        rdy_nxt = !skid_v_nxt;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            main_v_r <= 1'b0;
            skid_v_r <= 1'b0;
            main_r   <= '0;
            skid_r   <= '0;
            rdy_r    <= 1'b0;
        end else begin
            main_v_r <= main_v_nxt;
            skid_v_r <= skid_v_nxt;
            main_r   <= main_nxt;
            skid_r   <= skid_nxt;
            rdy_r    <= rdy_nxt;
        end
    end
endmodule

// ==== logic/dpd_demod.sv ====
// Differential PSK demodulator with decision-directed frequency discriminator
// Behaviour
// (RL1) Each symbol forms dot = I(k)I(k-1)+Q(k)Q(k-1) and cross = Q(k)I(k-1)-I(k)Q(k-1) against the rotated previous.
// (RL2) Per-symbol I and Q arrive as signed 8-bit values from the despreader.
// (RL3) DBPSK with no rotation decides purely on the sign of the dot product.
// (RL4) Rotation multiplies by (1+j)/2 for +45 or (1-j)/2 for -45, halving inside the rotation.
// (RL5) DQPSK decisions assume -45 rotation: signs (+,+),(-,+),(-,-),(+,-) give 0, 90, 180, 270 degrees.
// (RL6) For pi/4 QPSK the configuring side selects no rotation.
// (RL7) DBPSK frequency error is the cross product times the sign of the dot product.
// (RL8) DQPSK frequency error is sign(dot)*cross minus sign(cross)*dot.
// (RL9) One frequency error term per symbol goes to the loop filter.
// (RL10) With the internal modulator in use, transmit and receive IF clocks share one source.
// (RL11) Each decision leaves as a 2-bit (DQPSK) or 1-bit (DBPSK) symbol with a valid strobe.
`timescale 1ns/1ps
`include "dpd_consts.svh"
module dpd_demod (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Configuration
    input  wire dpd_pkg::dpd_mode_t   mode,
    input  wire dpd_pkg::dpd_rot_t    rot,
    // Despreader samples
    input  wire dpd_pkg::dpd_sym_t    sym_in,
    input  wire logic                 sym_valid,
    output logic                      sym_ready,
    // Loop filter and decision output
    output dpd_pkg::dpd_result_t      res,
    output logic                      res_valid,
    input  wire logic                 res_ready
);
    import dpd_pkg::*;

    localparam int SW = `DPD_SAMPLE_W; // RL2
    localparam int PW = `DPD_PROD_W;
    localparam int FW = `DPD_FERR_W;

    logic signed [SW-1:0] pi_r;
    logic signed [SW-1:0] pq_r;
    logic signed [SW-1:0] pi_nxt;
    logic signed [SW-1:0] pq_nxt;
    logic                 prev_v_r;
    logic                 prev_v_nxt;
    logic signed [PW-1:0] dot_r;
    logic signed [PW-1:0] cross_r;
    logic signed [PW-1:0] dot_nxt;
    logic signed [PW-1:0] cross_nxt;
    logic                 stage_v_r;
    logic                 stage_v_nxt;
    logic signed [SW:0]   sum_c;
    logic signed [SW:0]   dif_c;
    logic signed [SW:0]   ndif_c;
    logic                 accept;
    logic                 buf_ready;
    logic                 push;
    logic                 dneg;
    logic                 cneg;
    logic signed [FW-1:0] dot_e;
    logic signed [FW-1:0] cross_e;
    logic signed [FW-1:0] sd_cross;
    logic signed [FW-1:0] sc_dot;
    dpd_result_t          buf_in;

    assign sym_ready = buf_ready;
    assign accept    = sym_valid && buf_ready;
    assign push      = stage_v_r && buf_ready;

    // Rotation of the sample kept as next symbol's reference
    assign sum_c  = {sym_in.i[SW-1], sym_in.i} + {sym_in.q[SW-1], sym_in.q};
    assign dif_c  = {sym_in.i[SW-1], sym_in.i} - {sym_in.q[SW-1], sym_in.q};
    assign ndif_c = {sym_in.q[SW-1], sym_in.q} - {sym_in.i[SW-1], sym_in.i};

    always_comb begin
        pi_nxt     = pi_r;
        pq_nxt     = pq_r;
        prev_v_nxt = prev_v_r;
        if (accept) begin
            prev_v_nxt = 1'b1;
            case (rot)
                DPD_ROT_P45: begin
                    pi_nxt = dif_c[SW:1]; // RL4
                    pq_nxt = sum_c[SW:1]; // RL4
                end
                DPD_ROT_M45: begin
                    pi_nxt = sum_c[SW:1]; // RL4
                    pq_nxt = ndif_c[SW:1]; // RL4
                end
                default: begin
                    pi_nxt = sym_in.i; // RL3
                    pq_nxt = sym_in.q;
                end
            endcase
        end
    end

    // Product stage; first symbol after reset has no reference and is dropped
    always_comb begin
        dot_nxt     = dot_r;
        cross_nxt   = cross_r;
        stage_v_nxt = stage_v_r;
        if (buf_ready) begin
            stage_v_nxt = accept && prev_v_r; // RL9
        end
        if (accept) begin
            dot_nxt   = PW'(sym_in.i) * PW'(pi_r) + PW'(sym_in.q) * PW'(pq_r); // RL1
            cross_nxt = PW'(sym_in.q) * PW'(pi_r) - PW'(sym_in.i) * PW'(pq_r); // RL1
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pi_r      <= '0;
            pq_r      <= '0;
            prev_v_r  <= 1'b0;
            dot_r     <= '0;
            cross_r   <= '0;
            stage_v_r <= 1'b0;
        end else begin
            pi_r      <= pi_nxt;
            pq_r      <= pq_nxt;
            prev_v_r  <= prev_v_nxt;
            dot_r     <= dot_nxt;
            cross_r   <= cross_nxt;
            stage_v_r <= stage_v_nxt;
        end
    end

    // Decisions and frequency error from the product signs
    assign dneg    = dot_r[PW-1];
    assign cneg    = cross_r[PW-1];
    assign dot_e   = {dot_r[PW-1], dot_r};
    assign cross_e = {cross_r[PW-1], cross_r};

    always_comb begin
        sd_cross = dneg ? -cross_e : cross_e; // RL7
        sc_dot   = cneg ? -dot_e : dot_e;
        buf_in   = '0;
        if (mode == DPD_QPSK) begin
            buf_in.sym  = {cneg, dneg ^ cneg}; // RL5
            buf_in.ferr = sd_cross - sc_dot; // RL8
        end else begin
            buf_in.sym  = {1'b0, dneg}; // RL3
            buf_in.ferr = sd_cross; // RL7
        end
    end

    dpd_skid #(
        .W($bits(dpd_result_t))
    ) u_skid (
        .clk       (clk),
        .rst_b     (rst_b),
        .in_valid  (stage_v_r),
        .in_ready  (buf_ready),
        .in_data   (buf_in),
        .out_valid (res_valid), // RL11
        .out_ready (res_ready),
        .out_data  (res)
    );

    // Checks
    property p_products;
        @(posedge clk) disable iff (!rst_b)
        accept && prev_v_r |=> stage_v_r
            && dot_r == $past(sym_in.i) * $past(pi_r) + $past(sym_in.q) * $past(pq_r)
            && cross_r == $past(sym_in.q) * $past(pi_r) - $past(sym_in.i) * $past(pq_r);
    endproperty
    a_products: assert property (p_products) else $error("dot or cross product wrong"); // RL1

    property p_no_take;
        @(posedge clk) disable iff (!rst_b)
        !sym_ready |=> $stable(pi_r) && $stable(pq_r) && $stable(prev_v_r);
    endproperty
    a_no_take: assert property (p_no_take) else $error("sample taken while not ready"); // RL2

    property p_bpsk_dec;
        @(posedge clk) disable iff (!rst_b)
        push && mode == DPD_BPSK |-> buf_in.sym == {1'b0, dot_r[PW-1]};
    endproperty
    a_bpsk_dec: assert property (p_bpsk_dec) else $error("dbpsk decision not dot sign"); // RL3

    property p_rot;
        @(posedge clk) disable iff (!rst_b)
        accept && rot == DPD_ROT_P45 |=> pi_r == $past(dif_c[SW:1]) && pq_r == $past(sum_c[SW:1]);
    endproperty
    a_rot: assert property (p_rot) else $error("plus 45 rotation wrong"); // RL4

    property p_qpsk_dec;
        @(posedge clk) disable iff (!rst_b)
        push && mode == DPD_QPSK |-> buf_in.sym == (!dneg && !cneg ? 2'h0 : dneg && !cneg ? 2'h1
            : dneg && cneg ? 2'h2 : 2'h3);
    endproperty
    a_qpsk_dec: assert property (p_qpsk_dec) else $error("dqpsk decision wrong"); // RL5

    property p_bpsk_ferr;
        @(posedge clk) disable iff (!rst_b)
        push && mode == DPD_BPSK |-> buf_in.ferr == (dneg ? -cross_e : cross_e);
    endproperty
    a_bpsk_ferr: assert property (p_bpsk_ferr) else $error("dbpsk frequency error wrong"); // RL7

    property p_qpsk_ferr;
        @(posedge clk) disable iff (!rst_b)
        push && mode == DPD_QPSK |-> buf_in.ferr == (dneg ? -cross_e : cross_e) - (cneg ? -dot_e : dot_e);
    endproperty
    a_qpsk_ferr: assert property (p_qpsk_ferr) else $error("dqpsk frequency error wrong"); // RL8

    property p_deliver;
        @(posedge clk) disable iff (!rst_b)
        push |=> res_valid;
    endproperty
    a_deliver: assert property (p_deliver) else $error("term not delivered"); // RL9

    property p_hold;
        @(posedge clk) disable iff (!rst_b)
        res_valid && !res_ready |=> res_valid && $stable(res);
    endproperty
    a_hold: assert property (p_hold) else $error("output dropped under stall"); // RL11

    property p_rot_m45;
        @(posedge clk) disable iff (!rst_b)
        accept && rot == DPD_ROT_M45 |=> int'(pi_r) == (int'($past(sym_in.i)) + int'($past(sym_in.q))) >>> 1
            && int'(pq_r) == (int'($past(sym_in.q)) - int'($past(sym_in.i))) >>> 1;
    endproperty
    a_rot_m45: assert property (p_rot_m45) else $error("minus 45 rotation wrong"); // RL4

    property p_no_rot;
        @(posedge clk) disable iff (!rst_b)
        accept && rot == DPD_ROT_NONE |=> pi_r == $past(sym_in.i) && pq_r == $past(sym_in.q);
    endproperty
    a_no_rot: assert property (p_no_rot) else $error("unrotated reference wrong"); // RL3

    property p_first_ref;
        @(posedge clk) disable iff (!rst_b)
        accept && !prev_v_r |=> !stage_v_r;
    endproperty
    a_first_ref: assert property (p_first_ref) else $error("result made without reference"); // RL9
endmodule

// ==== bench/dpd_sink.sv ====
// Loop filter side model that takes results and can stall
`timescale 1ns/1ps
module dpd_sink (
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_b,
    // Result stream
    input  wire dpd_pkg::dpd_result_t res,
    input  wire logic                 res_valid,
    output logic                      res_ready,
    // Stall request
    input  wire logic                 hold
);
    import dpd_pkg::*;
    dpd_result_t rcv [0:31];
    int          n_rcv;
    assign res_ready = !hold;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            n_rcv <= 0;
        end else if (res_valid && res_ready && n_rcv < 32) begin
            rcv[n_rcv] <= res;
            n_rcv      <= n_rcv + 1;
        end
    end
endmodule

// ==== bench/dpd_demod_tb.sv ====
// Self-checking bench for the differential demodulator
`timescale 1ns/1ps
module dpd_demod_tb;
    import dpd_pkg::*;
    logic        clk, rst_b, sym_valid, sym_ready, res_valid, res_ready, hold;
    dpd_mode_t   mode;
    dpd_rot_t    rot;
    dpd_sym_t    sym_in;
    dpd_result_t res;
    dpd_sym_t    smp [0:15];
    logic [19:0] exp_a [0:15];
    int          bad_count, total_checks, cyc;

    dpd_demod u_dut (.clk(clk), .rst_b(rst_b), .mode(mode), .rot(rot), .sym_in(sym_in), .sym_valid(sym_valid),
                     .sym_ready(sym_ready), .res(res), .res_valid(res_valid), .res_ready(res_ready));
    dpd_sink u_sink (.clk(clk), .rst_b(rst_b), .res(res), .res_valid(res_valid), .res_ready(res_ready), .hold(hold));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task end_sim;
        $display("Checks made %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            bad_count++;
            end_sim;
        end
    end

    task check(string what, logic [19:0] seen, logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    function automatic dpd_sym_t mk(int i, int q);
        return {i[7:0], q[7:0]};
    endfunction

    // Reference result from previous and current sample
    function automatic logic [19:0] expect_res(dpd_sym_t p, dpd_sym_t c);
        int pi, pq, d, x, f;
        logic [1:0] s;
        pi = p.i;
        pq = p.q;
        if (rot == DPD_ROT_P45) begin
            pi = (int'(p.i) - int'(p.q)) >>> 1;
            pq = (int'(p.i) + int'(p.q)) >>> 1;
        end else if (rot == DPD_ROT_M45) begin
            pi = (int'(p.i) + int'(p.q)) >>> 1;
            pq = (int'(p.q) - int'(p.i)) >>> 1;
        end
        d = c.i * pi + c.q * pq;
        x = c.q * pi - c.i * pq;
        if (mode == DPD_BPSK) begin
            s = {1'b0, d < 0};
            f = (d < 0) ? -x : x;
        end else begin
            s = (d >= 0) ? ((x >= 0) ? 2'h0 : 2'h3) : ((x >= 0) ? 2'h1 : 2'h2);
            f = ((d < 0) ? -x : x) - ((x < 0) ? -d : d);
        end
        return {s, f[17:0]};
    endfunction

    task automatic send(dpd_sym_t s);
        int w;
        sym_in    = s;
        sym_valid = 1'b1;
        w         = 0;
        while (sym_ready !== 1'b1 && w < 100) begin
            @(negedge clk);
            w++;
        end
        check("send_wait", 20'(w < 100), 20'h1);
        @(negedge clk);
    endtask

    // Reset, stream n samples, wait for n-1 results
    task automatic run(int n);
        int w;
        rst_b     = 1'b0;
        sym_valid = 1'b0;
        repeat (6) @(negedge clk);
        check("ready_in_reset", {19'h0, sym_ready}, 20'h0);
        check("valid_in_reset", {19'h0, res_valid}, 20'h0);
        rst_b = 1'b1;
        @(negedge clk);
        for (int k = 0; k < n; k++) begin
            send(smp[k]);
            if (k > 0) exp_a[k-1] = expect_res(smp[k-1], smp[k]);
        end
        sym_valid = 1'b0;
        sym_in    = ~sym_in;
        w         = 0;
        while (u_sink.n_rcv < n - 1 && w < 200) begin
            @(negedge clk);
            w++;
        end
        repeat (5) @(negedge clk);
        check("result_count", 20'(u_sink.n_rcv), 20'(n - 1));
    endtask

    task t_bpsk;
        mode = DPD_BPSK;
        rot  = DPD_ROT_NONE;
        smp[0] = mk(100, 20);
        smp[1] = mk(-90, -10);
        smp[2] = mk(-128, 127);
        smp[3] = mk(127, -128);
        smp[4] = mk(0, 0);
        smp[5] = mk(5, -3);
        smp[6] = mk(-1, 0);
        run(7);
        for (int k = 0; k < 6; k++) check("bpsk", u_sink.rcv[k], exp_a[k]);
        $display("test bpsk done");
    endtask

    task t_qpsk;
        mode = DPD_QPSK;
        rot  = DPD_ROT_M45;
        smp[0] = mk(100, 0);
        smp[1] = mk(100, 0);
        smp[2] = mk(0, 100);
        smp[3] = mk(0, -100);
        smp[4] = mk(-100, 0);
        run(5);
        for (int k = 0; k < 4; k++) begin
            check("qpsk", u_sink.rcv[k], exp_a[k]);
            check("qpsk_step", 20'(u_sink.rcv[k].sym), 20'(k));
        end
        $display("test qpsk done");
    endtask

    task t_pi4;
        mode = DPD_QPSK;
        rot  = DPD_ROT_NONE;
        smp[0] = mk(100, 0);
        smp[1] = mk(70, 70);
        smp[2] = mk(0, -100);
        smp[3] = mk(70, 70);
        smp[4] = mk(100, 0);
        run(5);
        for (int k = 0; k < 4; k++) check("pi4", u_sink.rcv[k], exp_a[k]);
        $display("test pi4 done");
    endtask

    task t_rot;
        mode = DPD_BPSK;
        rot  = DPD_ROT_P45;
        smp[0] = mk(-77, 33);
        smp[1] = mk(61, -128);
        smp[2] = mk(127, 127);
        smp[3] = mk(-3, 9);
        run(4);
        for (int k = 0; k < 3; k++) check("rot_p45", u_sink.rcv[k], exp_a[k]);
        $display("test rotation done");
    endtask

    task t_stall;
        mode = DPD_QPSK;
        rot  = DPD_ROT_P45;
        hold = 1'b1;
        for (int k = 0; k < 8; k++) smp[k] = mk(k * 31 - 120, 90 - k * 23);
        fork
            run(8);
            begin
                repeat (30) @(negedge clk);
                check("ready_stalled", {19'h0, sym_ready}, 20'h0);
                hold = 1'b0;
            end
        join
        for (int k = 0; k < 7; k++) check("stall", u_sink.rcv[k], exp_a[k]);
        $display("test stall done");
    endtask

    initial begin
        rst_b        = 1'b0;
        sym_valid    = 1'b0;
        sym_in       = '0;
        hold         = 1'b0;
        mode         = DPD_BPSK;
        rot          = DPD_ROT_NONE;
        bad_count    = 0;
        total_checks = 0;
        cyc          = 0;
        @(negedge clk);
        t_bpsk;
        t_qpsk;
        t_pi4;
        t_rot;
        t_stall;
        end_sim;
    end
endmodule
